// ===== design/smi_defs.vh
// Constants of the sync message interrupt block: register indices,
// bit positions, reset values and the message width.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
`ifndef SMI_DEFS_VH
`define SMI_DEFS_VH

// ============================================================
// Register indices; the byte address is four times the index.
`define SMI_IDX_EVT_STAT    10'h070
`define SMI_IDX_EVT_EN      10'h071
`define SMI_IDX_UNS_STAT    10'h074
`define SMI_IDX_UNS_EN      10'h075
`define SMI_IDX_MATCH_ONE   10'h076
`define SMI_IDX_MATCH_TWO   10'h077
`define SMI_IDX_MATCH_THREE 10'h078
`define SMI_IDX_TX_REPEAT   10'h079
`define SMI_IDX_RX_MSG      10'h07a
`define SMI_ADDR_W          12

// ============================================================
// Bit positions inside the event and unstable status and enable registers.
`define SMI_BIT_MATCH_THREE 7
`define SMI_BIT_MATCH_TWO   6
`define SMI_BIT_FULL        3
`define SMI_BIT_EMPTY       2
`define SMI_BIT_MATCH_ONE   1
`define SMI_BIT_CHANGE      0
`define SMI_BIT_UNSTABLE    6

// ============================================================
// Reset values and widths.
`define SMI_RST_EVT_STAT    8'h00
`define SMI_RST_EVT_EN      8'h00
`define SMI_RST_UNS_STAT    8'h00
`define SMI_RST_UNS_EN      8'h00
`define SMI_RST_MATCH       6'h00
`define SMI_RST_TX_REPEAT   8'h01
`define SMI_MSG_W           6
`define SMI_CNT_W           8

`endif

// ===== design/smi_intr.v
// Sync message interrupt logic: event status and enable registers, the
// unstable-message registers, match and repeat settings, and an AHB-Lite slave.
// Assumes the message detector, filter and transmitter share clk and give
// one-cycle strobes; software is the only master on the register bus.
//
// Notes on behaviour
// - Change event set on filtered message change.
// - Enable register eight bits; bits 7,6 gate matches.
// - Enable bit 3 gates receive-register-full interrupt.
// - Enable bit 2 gates transmit-register-empty interrupt.
// - Enable bit 1 match one, bit 0 change.
// - Unstable bit 6 set on valid message change.
// - No unstable event before first valid message.
// - Unstable status clears on read; reset zero.
// - Unstable enable bit 6 gates unstable interrupt.
// - Match events need equality and filter validation.
// - Full event on any valid message, unfiltered.
// - Empty event after programmed transmit repetitions.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "smi_defs.vh"

module smi_intr
#(
   parameter MSG_W = `SMI_MSG_W,
   parameter CNT_W = `SMI_CNT_W
)
(
   input  wire                     clk,
   input  wire                     resetn,
   // AHB-Lite slave.
   input  wire                     hsel,
   input  wire [`SMI_ADDR_W-1:0]   haddr,
   input  wire [1:0]               htrans,
   input  wire                     hwrite,
   input  wire [2:0]               hsize,
   input  wire [31:0]              hwdata,
   input  wire                     hready,
   output reg                      hreadyout_ff,
   output reg                      hresp_ff,
   output reg  [31:0]              hrdata_ff,
   // Message detector, filter and transmitter strobes.
   input  wire [MSG_W-1:0]         rx_msg,
   input  wire                     rx_msg_valid,
   input  wire                     rx_filter_ok,
   input  wire                     tx_msg_load,
   input  wire                     tx_msg_sent,
   // Interrupt request, level, active high.
   output reg                      irq_ff
);

   // ============================================================
   // Register selector codes.
   localparam SEL_NONE     = 4'd0;
   localparam SEL_EVT_STAT = 4'd1;
   localparam SEL_EVT_EN   = 4'd2;
   localparam SEL_UNS_STAT = 4'd3;
   localparam SEL_UNS_EN   = 4'd4;
   localparam SEL_MATCH1   = 4'd5;
   localparam SEL_MATCH2   = 4'd6;
   localparam SEL_MATCH3   = 4'd7;
   localparam SEL_TX_REP   = 4'd8;
   localparam SEL_RX_MSG   = 4'd9;

   localparam [7:0] UNS_MASK = 8'h01 << `SMI_BIT_UNSTABLE;

   // ============================================================
   // Address decode, shared by the read and write paths.
   function [3:0] reg_sel;
      input [`SMI_ADDR_W-1:0] addr;
      begin
         case (addr)
            {`SMI_IDX_EVT_STAT, 2'b00}:    reg_sel = SEL_EVT_STAT;
            {`SMI_IDX_EVT_EN, 2'b00}:      reg_sel = SEL_EVT_EN;
            {`SMI_IDX_UNS_STAT, 2'b00}:    reg_sel = SEL_UNS_STAT;
            {`SMI_IDX_UNS_EN, 2'b00}:      reg_sel = SEL_UNS_EN;
            {`SMI_IDX_MATCH_ONE, 2'b00}:   reg_sel = SEL_MATCH1;
            {`SMI_IDX_MATCH_TWO, 2'b00}:   reg_sel = SEL_MATCH2;
            {`SMI_IDX_MATCH_THREE, 2'b00}: reg_sel = SEL_MATCH3;
            {`SMI_IDX_TX_REPEAT, 2'b00}:   reg_sel = SEL_TX_REP;
            {`SMI_IDX_RX_MSG, 2'b00}:      reg_sel = SEL_RX_MSG;
            default:                       reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   // ============================================================
   // Declarations.
   reg  [7:0]          evt_stat_ff;
   reg  [7:0]          evt_en_ff;
   reg  [7:0]          uns_stat_ff;
   reg  [7:0]          uns_en_ff;
   reg  [MSG_W-1:0]    match_one_ff;
   reg  [MSG_W-1:0]    match_two_ff;
   reg  [MSG_W-1:0]    match_three_ff;
   reg  [CNT_W-1:0]    tx_repeat_ff;
   reg  [CNT_W-1:0]    tx_cnt_ff;
   reg                 tx_empty_ff;
   reg                 wr_pend_ff;
   reg                 rd_pend_ff;
   reg  [3:0]          wr_sel_ff;
   reg  [3:0]          rd_sel_ff;

   reg  [7:0]          nxt_evt_stat;
   reg  [7:0]          nxt_uns_stat;
   reg  [7:0]          nxt_evt_en;
   reg  [7:0]          nxt_uns_en;
   reg  [7:0]          evt_set;
   reg  [7:0]          evt_clr;
   reg  [7:0]          uns_set;
   reg  [7:0]          uns_clr;
   reg  [31:0]         rd_word;

   wire                ev_change;
   wire [2:0]          ev_match;
   wire                ev_full;
   wire                ev_unstable;
   wire [MSG_W-1:0]    last_msg;
   wire                take;
   wire                wr_now;
   wire                rd_now;
   wire [CNT_W-1:0]    tx_goal;

   // ============================================================
   // Message tracking.
   smi_msg_track
   #(
      .MSG_W (MSG_W)
   )
   u_track
   (
      .clk          (clk),
      .resetn       (resetn),
      .rx_msg       (rx_msg),
      .rx_msg_valid (rx_msg_valid),
      .rx_filter_ok (rx_filter_ok),
      .match_msgs   ({match_three_ff, match_two_ff, match_one_ff}),
      .change_ff    (ev_change),
      .match_ff     (ev_match),
      .full_ff      (ev_full),
      .unstable_ff  (ev_unstable),
      .last_msg_ff  (last_msg)
   );

   // ============================================================
   // Transmit repetition counter.
   // A repeat count of zero is treated as one so the event cannot be lost.
   assign tx_goal = (tx_repeat_ff == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1}
                                                    : tx_repeat_ff;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_cnt_ff   <= {CNT_W{1'b0}};
         tx_empty_ff <= 1'b0;
      end
      else
      begin
         tx_empty_ff <= 1'b0;
         if (tx_msg_load)
         begin
            tx_cnt_ff <= {CNT_W{1'b0}};
         end
         else if (tx_msg_sent)
         begin
            if (tx_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1} >= tx_goal)
            begin
               tx_cnt_ff   <= {CNT_W{1'b0}};
               tx_empty_ff <= 1'b1;
            end
            else
            begin
               tx_cnt_ff <= tx_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // ============================================================
   // Bus phases.
   // Reads take one wait state so that the read data and the clear on read
   // happen together, after any write that precedes them has landed.
   assign take   = hsel & htrans[1] & hready;
   assign wr_now = wr_pend_ff;
   assign rd_now = rd_pend_ff;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_pend_ff   <= 1'b0;
         rd_pend_ff   <= 1'b0;
         wr_sel_ff    <= SEL_NONE;
         rd_sel_ff    <= SEL_NONE;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
         hrdata_ff    <= 32'h0000_0000;
      end
      else
      begin
         hresp_ff   <= 1'b0;
         wr_pend_ff <= take & hwrite;
         rd_pend_ff <= take & !hwrite;
         if (take)
         begin
            wr_sel_ff <= reg_sel(haddr);
            rd_sel_ff <= reg_sel(haddr);
         end
         if (take & !hwrite)
         begin
            hreadyout_ff <= 1'b0;
         end
         else if (rd_now)
         begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= rd_word;
         end
      end
   end

   // ============================================================
   // Read multiplexer; unmapped addresses read as zero.
   always @*
   begin
      rd_word = 32'h0000_0000;
      case (rd_sel_ff)
         SEL_EVT_STAT: rd_word[7:0]       = evt_stat_ff;
         SEL_EVT_EN:   rd_word[7:0]       = evt_en_ff;
         SEL_UNS_STAT: rd_word[7:0]       = uns_stat_ff;
         SEL_UNS_EN:   rd_word[7:0]       = uns_en_ff;
         SEL_MATCH1:   rd_word[MSG_W-1:0] = match_one_ff;
         SEL_MATCH2:   rd_word[MSG_W-1:0] = match_two_ff;
         SEL_MATCH3:   rd_word[MSG_W-1:0] = match_three_ff;
         SEL_TX_REP:   rd_word[CNT_W-1:0] = tx_repeat_ff;
         SEL_RX_MSG:   rd_word[MSG_W-1:0] = last_msg;
         default:      rd_word            = 32'h0000_0000;
      endcase
   end

   // ============================================================
   // Status and enable next values.
   // A new event in the same cycle as its clear survives the clear.
   always @*
   begin
      evt_set = 8'h00;
      evt_set[`SMI_BIT_MATCH_THREE] = ev_match[2];
      evt_set[`SMI_BIT_MATCH_TWO]   = ev_match[1];
      evt_set[`SMI_BIT_FULL]        = ev_full;
      evt_set[`SMI_BIT_EMPTY]       = tx_empty_ff;
      evt_set[`SMI_BIT_MATCH_ONE]   = ev_match[0];
      evt_set[`SMI_BIT_CHANGE]      = ev_change;
      uns_set = 8'h00;
      uns_set[`SMI_BIT_UNSTABLE]    = ev_unstable;

      evt_clr = 8'h00;
      uns_clr = 8'h00;
      if (rd_now && rd_sel_ff == SEL_EVT_STAT)
      begin
         evt_clr = 8'hff;
      end
      if (rd_now && rd_sel_ff == SEL_UNS_STAT)
      begin
         uns_clr = 8'hff;
      end
      if (wr_now && wr_sel_ff == SEL_EVT_STAT)
      begin
         evt_clr = evt_clr | hwdata[7:0];
      end
      if (wr_now && wr_sel_ff == SEL_UNS_STAT)
      begin
         uns_clr = uns_clr | hwdata[7:0];
      end

      nxt_evt_stat = (evt_stat_ff & ~evt_clr) | evt_set;
      nxt_uns_stat = ((uns_stat_ff & ~uns_clr) | uns_set) & UNS_MASK;

      nxt_evt_en = evt_en_ff;
      nxt_uns_en = uns_en_ff;
      if (wr_now && wr_sel_ff == SEL_EVT_EN)
      begin
         nxt_evt_en = hwdata[7:0];
      end
      if (wr_now && wr_sel_ff == SEL_UNS_EN)
      begin
         nxt_uns_en = hwdata[7:0] & UNS_MASK;
      end
   end

   // ============================================================
   // Register storage.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         evt_stat_ff    <= `SMI_RST_EVT_STAT;
         evt_en_ff      <= `SMI_RST_EVT_EN;
         uns_stat_ff    <= `SMI_RST_UNS_STAT;
         uns_en_ff      <= `SMI_RST_UNS_EN;
         match_one_ff   <= `SMI_RST_MATCH;
         match_two_ff   <= `SMI_RST_MATCH;
         match_three_ff <= `SMI_RST_MATCH;
         tx_repeat_ff   <= `SMI_RST_TX_REPEAT;
      end
      else
      begin
         evt_stat_ff <= nxt_evt_stat;
         evt_en_ff   <= nxt_evt_en;
         uns_stat_ff <= nxt_uns_stat;
         uns_en_ff   <= nxt_uns_en;
         if (wr_now)
         begin
            case (wr_sel_ff)
               SEL_MATCH1: match_one_ff   <= hwdata[MSG_W-1:0];
               SEL_MATCH2: match_two_ff   <= hwdata[MSG_W-1:0];
               SEL_MATCH3: match_three_ff <= hwdata[MSG_W-1:0];
               SEL_TX_REP: tx_repeat_ff   <= hwdata[CNT_W-1:0];
               default:    tx_repeat_ff   <= tx_repeat_ff;
            endcase
         end
      end
   end

   // ============================================================
   // Interrupt request.
   // Built from the next values so the request follows the event by one
   // cycle and drops in the cycle after the clearing read.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= (|(nxt_evt_stat & nxt_evt_en)) |
                   (|(nxt_uns_stat & nxt_uns_en));
      end
   end

endmodule // smi_intr

`default_nettype wire

// ===== design/smi_msg_track.v
// Tracks received sync messages and turns detector strobes into event pulses.
// Assumes the message detector and filter run on the same clock and give
// one-cycle strobes with the message held steady alongside them.
`timescale 1ns/1ns
`default_nettype none
`include "smi_defs.vh"

module smi_msg_track
#(
   parameter MSG_W = `SMI_MSG_W
)
(
   input  wire                 clk,
   input  wire                 resetn,
   input  wire [MSG_W-1:0]     rx_msg,
   input  wire                 rx_msg_valid,
   input  wire                 rx_filter_ok,
   input  wire [3*MSG_W-1:0]   match_msgs,
   output reg                  change_ff,
   output reg  [2:0]           match_ff,
   output reg                  full_ff,
   output reg                  unstable_ff,
   output reg  [MSG_W-1:0]     last_msg_ff
);

   reg              have_valid_ff;
   reg              have_filt_ff;
   reg [MSG_W-1:0]  filt_msg_ff;
   wire [2:0]       nxt_match;

   // ============================================================
   // Match comparators, one per programmed message.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_match
         assign nxt_match[gi] = rx_filter_ok &
                                (rx_msg == match_msgs[gi*MSG_W +: MSG_W]);
      end
   endgenerate

   // ============================================================
   // Event pulses and message history.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         change_ff     <= 1'b0;
         match_ff      <= 3'b000;
         full_ff       <= 1'b0;
         unstable_ff   <= 1'b0;
         last_msg_ff   <= {MSG_W{1'b0}};
         have_valid_ff <= 1'b0;
         have_filt_ff  <= 1'b0;
         filt_msg_ff   <= {MSG_W{1'b0}};
      end
      else
      begin
         match_ff    <= nxt_match;
         full_ff     <= rx_msg_valid;
         // The first valid message only arms the check; it is not unstable.
         unstable_ff <= rx_msg_valid & have_valid_ff & (rx_msg != last_msg_ff);
         // A filtered message counts as a change when it differs from the
         // last filtered one, or when it is the first since reset.
         change_ff   <= rx_filter_ok & (!have_filt_ff | (rx_msg != filt_msg_ff));
         if (rx_msg_valid)
         begin
            last_msg_ff   <= rx_msg;
            have_valid_ff <= 1'b1;
         end
         if (rx_filter_ok)
         begin
            filt_msg_ff  <= rx_msg;
            have_filt_ff <= 1'b1;
         end
      end
   end

endmodule // smi_msg_track

`default_nettype wire

// ===== tb/smi_intr_bench.sv
// Self-checking bench for the sync message interrupt block.
// Acts as the only AHB-Lite master and as the message detector and transmitter.
`timescale 1ns/1ns
`default_nettype none
module smi_intr_bench;
   localparam logic [11:0] A_ST = 12'h1c0;
   localparam logic [11:0] A_EN = 12'h1c4;
   localparam logic [11:0] A_US = 12'h1d0;
   localparam logic [11:0] A_UE = 12'h1d4;
   localparam logic [11:0] A_TR = 12'h1e4;
   localparam logic [7:0]  ST_ALL = 8'h4f;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [5:0]  rx_msg = 6'h00;
   logic        rx_msg_valid = 1'b0;
   logic        rx_filter_ok = 1'b0;
   logic        tx_msg_load = 1'b0;
   logic        tx_msg_sent = 1'b0;
   wire logic   hreadyout_ff;
   wire logic   hresp_ff;
   wire logic [31:0] hrdata_ff;
   wire logic   irq_ff;
   logic [31:0] rd;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;

   smi_intr uut
   (
      .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout_ff),
      .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff),
      .rx_msg(rx_msg), .rx_msg_valid(rx_msg_valid), .rx_filter_ok(rx_filter_ok),
      .tx_msg_load(tx_msg_load), .tx_msg_sent(tx_msg_sent), .irq_ff(irq_ff)
   );

   always #50 clk = ~clk;

   // ============================================================
   // Tasks; each starts and ends just after a rising edge.
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout_ff !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout_ff !== 1'b1) @(posedge clk);
      rd = hrdata_ff;
      check("response", {31'h0, hresp_ff}, 32'h0);
   endtask

   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(name, rd, exp);
   endtask

   // The message is scrambled after the strobe so that late sampling shows.
   task automatic rx(input logic [5:0] m, input logic v, input logic f);
      rx_msg <= m;
      rx_msg_valid <= v;
      rx_filter_ok <= f;
      @(posedge clk);
      rx_msg <= ~m;
      rx_msg_valid <= 1'b0;
      rx_filter_ok <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic tx(input logic ld);
      tx_msg_load <= ld;
      tx_msg_sent <= !ld;
      @(posedge clk);
      tx_msg_load <= 1'b0;
      tx_msg_sent <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq_ff}, {31'h0, e});
   endtask

   task automatic do_reset;
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   // ============================================================
   // Main sequence.
   initial
   begin
      do_reset();
      rdchk("enable", A_EN, 32'h0);
      rdchk("status", A_ST, 32'h0);
      rdchk("unstable", A_US, 32'h0);
      rdchk("unstable enable", A_UE, 32'h0);
      xfer(A_EN, 1'b1, 32'hff);
      rdchk("enable", A_EN, 32'hff);
      xfer(A_UE, 1'b1, 32'hffffffff);
      rdchk("unstable enable", A_UE, 32'h40);
      xfer(A_UE, 1'b1, 32'h0);
      xfer(A_EN, 1'b1, 32'h0);
      rdchk("unmapped", 12'h3fc, 32'h0);
      xfer(12'h1d8, 1'b1, 32'h11);
      xfer(12'h1dc, 1'b1, 32'h22);
      xfer(12'h1e0, 1'b1, 32'h33);
      rdchk("match three", 12'h1e0, 32'h33);
      rx(6'h11, 1'b1, 1'b1);
      rdchk("status", A_ST, 32'h0b);
      rdchk("unstable", A_US, 32'h0);
      rdchk("status", A_ST, 32'h0);
      rx(6'h22, 1'b1, 1'b1);
      rdchk("status", A_ST, 32'h49);
      rdchk("unstable", A_US, 32'h40);
      rdchk("unstable", A_US, 32'h0);
      rx(6'h33, 1'b1, 1'b0);
      rdchk("status", A_ST, 32'h08);
      rdchk("unstable", A_US, 32'h40);
      rx(6'h33, 1'b1, 1'b1);
      rdchk("status", A_ST, 32'h89);
      rdchk("unstable", A_US, 32'h0);
      rx(6'h33, 1'b1, 1'b1);
      rdchk("status", A_ST, 32'h88);
      xfer(A_TR, 1'b1, 32'h3);
      tx(1'b1);
      tx(1'b0);
      tx(1'b0);
      rdchk("status", A_ST, 32'h0);
      tx(1'b0);
      rdchk("status", A_ST, 32'h04);
      xfer(A_TR, 1'b1, 32'h1);
      tx(1'b1);
      tx(1'b0);
      rx(6'h22, 1'b1, 1'b1);
      rx(6'h11, 1'b1, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         xfer(A_EN, 1'b1, 32'h1 << i);
         irq_is(ST_ALL[i]);
      end
      xfer(A_EN, 1'b1, 32'h0);
      xfer(A_UE, 1'b1, 32'h40);
      irq_is(1'b1);
      xfer(A_UE, 1'b1, 32'h0);
      irq_is(1'b0);
      xfer(A_EN, 1'b1, 32'hff);
      xfer(A_UE, 1'b1, 32'h40);
      rx(6'h22, 1'b1, 1'b1);
      rdchk("status", A_ST, 32'h4f);
      rdchk("unstable", A_US, 32'h40);
      irq_is(1'b0);
      do_reset();
      rdchk("enable", A_EN, 32'h0);
      rdchk("repeat", A_TR, 32'h1);
      // With the unstable interrupt enabled, the first message must stay quiet.
      xfer(A_UE, 1'b1, 32'h40);
      rx(6'h05, 1'b1, 1'b0);
      rdchk("unstable", A_US, 32'h0);
      rdchk("status", A_ST, 32'h08);
      rdchk("last message", 12'h1e8, 32'h05);
      rx(6'h06, 1'b1, 1'b0);
      irq_is(1'b1);
      rdchk("unstable", A_US, 32'h40);
      rdchk("status", A_ST, 32'h08);
      // A repeated message leaves only the full event to raise the request.
      xfer(A_EN, 1'b1, 32'h08);
      rx(6'h06, 1'b1, 1'b0);
      irq_is(1'b1);
      summarize();
   end
endmodule // smi_intr_bench
`default_nettype wire

// ===== tb/smi_intr_checker.sv
// Checker for the sync message interrupt block, bound to its top module.
// Sees only the top ports; keeps its own shadow of the two enable registers.
`timescale 1ns/1ns
`default_nettype none
module smi_intr_checker
#(
   parameter MSG_W = 6
)
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             hsel,
   input wire logic [11:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout_ff,
   input wire logic             hresp_ff,
   input wire logic [31:0]      hrdata_ff,
   input wire logic [MSG_W-1:0] rx_msg,
   input wire logic             rx_msg_valid,
   input wire logic             irq_ff
);
   // ============================================================
   // Shadow state.
   logic             wr_ff;
   logic [11:0]      wa_ff;
   logic [7:0]       en_ff;
   logic             un_ff;
   logic             seen_ff;
   logic [MSG_W-1:0] last_ff;
   wire logic        rd_take = hsel && htrans[1] && hready && !hwrite;
   wire logic        wr_take = hsel && htrans[1] && hready && hwrite;

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         wr_ff <= 1'b0;
         wa_ff <= 12'h000;
         en_ff <= 8'h00;
         un_ff <= 1'b0;
      end
      else if (hready)
      begin
         wr_ff <= wr_take;
         wa_ff <= haddr;
         if (wr_ff && wa_ff == 12'h1c4)
            en_ff <= hwdata[7:0];
         if (wr_ff && wa_ff == 12'h1d4)
            un_ff <= hwdata[6];
      end

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         seen_ff <= 1'b0;
         last_ff <= {MSG_W{1'b0}};
      end
      else if (rx_msg_valid)
      begin
         seen_ff <= 1'b1;
         last_ff <= rx_msg;
      end

   // ============================================================
   // Assertions.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_resp_okay: assert property (!hresp_ff)
      else $error("slave gave an error response");
   a_read_wait: assert property (rd_take |=> !hreadyout_ff ##1 hreadyout_ff)
      else $error("read did not take exactly one wait state");
   a_write_nowait: assert property (wr_take |=> hreadyout_ff)
      else $error("write was stalled");
   a_wait_cause: assert property ($fell(hreadyout_ff) |-> $past(rd_take))
      else $error("wait state without a read");
   a_data_steady: assert property ($changed(hrdata_ff) |-> $rose(hreadyout_ff))
      else $error("read data changed outside a read");
   a_full_irq: assert property (rx_msg_valid && en_ff[3] |-> ##[1:2] irq_ff)
      else $error("enabled full event raised no interrupt");
   a_irq_quiet: assert property ((en_ff == 8'h00 && !un_ff) [*2] |-> !irq_ff)
      else $error("interrupt with every enable off");
   a_unst_first: assert property (rx_msg_valid && !seen_ff && en_ff == 8'h00 && un_ff && !irq_ff
      |=> (!irq_ff) [*2])
      else $error("unstable event on first message");
   a_unst_change: assert property (rx_msg_valid && seen_ff && rx_msg != last_ff && un_ff
      |-> ##[1:2] irq_ff)
      else $error("enabled unstable event raised no interrupt");
endmodule // smi_intr_checker

bind smi_intr smi_intr_checker #(.MSG_W(MSG_W)) u_chk
(
   .clk          (clk),
   .resetn       (resetn),
   .hsel         (hsel),
   .haddr        (haddr),
   .htrans       (htrans),
   .hwrite       (hwrite),
   .hwdata       (hwdata),
   .hready       (hready),
   .hreadyout_ff (hreadyout_ff),
   .hresp_ff     (hresp_ff),
   .hrdata_ff    (hrdata_ff),
   .rx_msg       (rx_msg),
   .rx_msg_valid (rx_msg_valid),
   .irq_ff       (irq_ff)
);
`default_nettype wire
